/* cbmie_pkg.sv */
// Function
// RL1: rotate left through carry: carry into bit 0, old bit 7 to carry, one cycle.
// RL2: rotate right through carry: carry into bit 7, old bit 0 to carry, one cycle.
// RL3: arithmetic right shift keeps bit 7, updates zero, carry, negative, overflow, one cycle.
// RL4: register bit to transfer flag copies chosen bit into T only, one cycle.
// RL5: transfer flag to register bit writes T into chosen bit, no flag change.
// RL6: overflow flag set and clear force V alone, one cycle each.
// RL7: global_irq_on_op sets I, global_irq_off_op clears I, one cycle, nothing else.
// RL8: half-carry set and clear force H alone, one cycle each.
// RL9: signed test set and clear force S alone, one cycle each.
// RL10: register move copies source in one cycle; pair copy moves two registers.
// RL11: indirect load post-increment reads byte then adds one to pointer, two cycles.
// RL12: indirect load pre-decrement subtracts one first then reads, two cycles.
// RL13: displaced load reads pointer plus displacement, pointer unchanged, two cycles.
// RL14: direct load reads byte at instruction address constant, two cycles, no flags.
// RL15: indirect store post-increment writes source then adds one to pointer, two cycles.
// RL16: indirect store pre-decrement subtracts one then writes source, two cycles.
// RL17: displaced store writes pointer plus displacement, pointer unchanged, two cycles.
// RL18: direct store writes source at address constant, two cycles, flags untouched.
// RL19: program memory read fetches Z byte into named register or R0, three cycles.
// RL20: program memory write stores R1:R0 word at Z, no fixed cycle count.
// RL21: stack push places source on stack, two cycles, flags unchanged.
// RL22: stack pop returns top byte into destination, two cycles, flags unchanged.
// RL23: logical right shift loads zero into bit 7, bit 0 to carry, one cycle.
// RL24: nibble exchange swaps upper and lower halves, one cycle, no flag change.
package cbmie_pkg;

  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_CONST = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_SP = 8'h0C;
  localparam int STATUS_BUSY_BIT = 8;
  localparam int REG_WIN_BIT = 7;
  localparam int CMD_WIDTH = 22;

  // status register bit positions
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;

  localparam logic [4:0] OP_NOP = 5'h00;
  localparam logic [4:0] OP_SHR = 5'h01;
  localparam logic [4:0] OP_RLC = 5'h02;
  localparam logic [4:0] OP_RRC = 5'h03;
  localparam logic [4:0] OP_SRA = 5'h04;
  localparam logic [4:0] OP_SWAP = 5'h05;
  localparam logic [4:0] OP_BSET = 5'h06;
  localparam logic [4:0] OP_BCLR = 5'h07;
  localparam logic [4:0] OP_B2T = 5'h08;
  localparam logic [4:0] OP_T2B = 5'h09;
  localparam logic [4:0] OP_MOV = 5'h0A;
  localparam logic [4:0] OP_MOVP = 5'h0B;
  localparam logic [4:0] OP_LDI = 5'h0C;
  localparam logic [4:0] OP_LD_IND = 5'h0D;
  localparam logic [4:0] OP_LD_DISP = 5'h0E;
  localparam logic [4:0] OP_LD_DIR = 5'h0F;
  localparam logic [4:0] OP_ST_IND = 5'h10;
  localparam logic [4:0] OP_ST_DISP = 5'h11;
  localparam logic [4:0] OP_ST_DIR = 5'h12;
  localparam logic [4:0] OP_PRD = 5'h13;
  localparam logic [4:0] OP_PRD_R0 = 5'h14;
  localparam logic [4:0] OP_PWR = 5'h15;
  localparam logic [4:0] OP_PUSH = 5'h16;
  localparam logic [4:0] OP_POP = 5'h17;

  localparam logic [1:0] MODE_PLAIN = 2'h0;
  localparam logic [1:0] MODE_POSTINC = 2'h1;
  localparam logic [1:0] MODE_PREDEC = 2'h2;

  // pointer pairs X, Y, Z start at this register, two apart
  localparam logic [4:0] PTR_BASE = 5'h1A;
  localparam logic [4:0] Z_LO = 5'h1E;
  localparam logic [5:0] DISP_MASK = 6'h3F;

  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [15:0] SP_RESET = 16'h01FF;

  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] ptr;
    logic [2:0] bitSel;
    logic [4:0] rr;
    logic [4:0] rd;
    logic [4:0] op;
  } cbmie_cmd_s;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } cbmie_dmreq_s;

  typedef struct packed {
    logic [14:0] addr;
    logic [15:0] wdata;
    logic we;
    logic re;
  } cbmie_pmreq_s;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_EXEC,
    ST_MEM,
    ST_PRD2,
    ST_PRD3,
    ST_PWR
  } cbmie_state_e;

endpackage : cbmie_pkg

/* cbmie_exec.sv */
// Design decisions made here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module cbmie_exec (
  input wire logic clock,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output var cbmie_pkg::cbmie_dmreq_s dmReq,
  input wire logic [7:0] dmRdData,
  output var cbmie_pkg::cbmie_pmreq_s pmReq,
  input wire logic [15:0] pmRdData,
  input wire logic pmWrDone,
  output logic busy
);

  cbmie_pkg::cbmie_state_e state_r;
  cbmie_pkg::cbmie_state_e state_nxt;
  cbmie_pkg::cbmie_cmd_s cmd_r;
  logic [15:0] const_r;
  logic [15:0] sp_r;
  logic [7:0] stat_r;
  logic [7:0] stat_nxt;
  logic [7:0] regs [32];
  logic wrPend_r;
  logic [7:0] wrAddr_r;

  // bus slave: always ready, always OKAY; single word transfers only
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  wire logic addrPhase = hsel && htrans[1] && hready;
  wire logic mapped = (haddr[31:8] == 24'h0) && (haddr[1:0] == 2'h0) && (hsize == 3'h2);
  wire logic idle = (state_r == cbmie_pkg::ST_IDLE);
  wire logic wrCmd = wrPend_r && idle && (wrAddr_r == cbmie_pkg::ADDR_CMD);
  wire logic wrConst = wrPend_r && idle && (wrAddr_r == cbmie_pkg::ADDR_CONST);
  wire logic wrStatus = wrPend_r && idle && (wrAddr_r == cbmie_pkg::ADDR_STATUS);
  wire logic wrSp = wrPend_r && idle && (wrAddr_r == cbmie_pkg::ADDR_SP);
  wire logic wrReg = wrPend_r && idle && wrAddr_r[cbmie_pkg::REG_WIN_BIT];
  wire logic [4:0] regIdx = wrAddr_r[6:2];

  wire logic [31:0] rdVal =
    !mapped ? 32'h0 :
    (haddr[7:0] == cbmie_pkg::ADDR_CMD) ? {10'h0, cmd_r} :
    (haddr[7:0] == cbmie_pkg::ADDR_CONST) ? {16'h0, const_r} :
    (haddr[7:0] == cbmie_pkg::ADDR_STATUS) ? {23'h0, !idle, stat_r} :
    (haddr[7:0] == cbmie_pkg::ADDR_SP) ? {16'h0, sp_r} :
    haddr[cbmie_pkg::REG_WIN_BIT] ? {24'h0, regs[haddr[6:2]]} : 32'h0;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wrPend_r <= 1'b0;
      wrAddr_r <= 8'h00;
      hrdata <= 32'h0;
    end else begin
      wrPend_r <= addrPhase && hwrite && mapped;
      wrAddr_r <= haddr[7:0];
      if (addrPhase && !hwrite) begin
        hrdata <= rdVal;
      end
    end
  end

  // decode of the latched command
  wire logic [4:0] op = cmd_r.op;
  wire logic [7:0] dst = regs[cmd_r.rd];
  wire logic [7:0] src = regs[cmd_r.rr];
  wire logic [4:0] ptrLo = cbmie_pkg::PTR_BASE + {2'h0, cmd_r.ptr, 1'b0};
  wire logic [4:0] ptrHi = ptrLo + 5'h01;
  wire logic [15:0] ptrVal = {regs[ptrHi], regs[ptrLo]};
  wire logic [15:0] zVal = {regs[cbmie_pkg::Z_LO + 5'h01], regs[cbmie_pkg::Z_LO]};
  wire logic [15:0] ptrInc = ptrVal + 16'h0001;
  wire logic [15:0] ptrDec = ptrVal - 16'h0001;
  wire logic [15:0] dispAddr = ptrVal + {10'h0, const_r[5:0] & cbmie_pkg::DISP_MASK};
  wire logic tFlag = stat_r[cbmie_pkg::FLAG_T];
  wire logic cFlag = stat_r[cbmie_pkg::FLAG_C];
  wire logic [7:0] bitMask = 8'h01 << cmd_r.bitSel;

  wire logic isLdInd = (op == cbmie_pkg::OP_LD_IND);
  wire logic isStInd = (op == cbmie_pkg::OP_ST_IND);
  wire logic isDisp = (op == cbmie_pkg::OP_LD_DISP) || (op == cbmie_pkg::OP_ST_DISP);
  wire logic isDir = (op == cbmie_pkg::OP_LD_DIR) || (op == cbmie_pkg::OP_ST_DIR);
  wire logic isPush = (op == cbmie_pkg::OP_PUSH);
  wire logic isPop = (op == cbmie_pkg::OP_POP);
  wire logic isLoad = isLdInd || (op == cbmie_pkg::OP_LD_DISP) ||
                      (op == cbmie_pkg::OP_LD_DIR) || isPop;
  wire logic isStore = isStInd || (op == cbmie_pkg::OP_ST_DISP) ||
                       (op == cbmie_pkg::OP_ST_DIR) || isPush;
  wire logic isMem = isLoad || isStore;
  wire logic isPrd = (op == cbmie_pkg::OP_PRD) || (op == cbmie_pkg::OP_PRD_R0);
  wire logic isPwr = (op == cbmie_pkg::OP_PWR);
  wire logic isShift = (op == cbmie_pkg::OP_SHR) || (op == cbmie_pkg::OP_RLC) ||
                       (op == cbmie_pkg::OP_RRC) || (op == cbmie_pkg::OP_SRA);
  wire logic ptrUpd = (isLdInd || isStInd) && (cmd_r.mode != cbmie_pkg::MODE_PLAIN);
  wire logic exec = (state_r == cbmie_pkg::ST_EXEC);

  // pre-decrement addresses the new pointer; post-increment the old one
  wire logic [15:0] indAddr = // RL12 RL16
    (cmd_r.mode == cbmie_pkg::MODE_PREDEC) ? ptrDec : ptrVal;
  wire logic [15:0] ptrNew = (cmd_r.mode == cbmie_pkg::MODE_PREDEC) ? ptrDec : ptrInc; // RL11 RL15
  wire logic [15:0] memAddr =
    (isLdInd || isStInd) ? indAddr :
    isDisp ? dispAddr : // RL13 RL17
    isDir ? const_r : // RL14 RL18
    isPush ? sp_r : sp_r + 16'h0001; // RL21 RL22

  logic [7:0] shRes;
  logic shC;
  always_comb begin
    shRes = dst;
    shC = cFlag;
    case (op)
      cbmie_pkg::OP_SHR: begin
        shRes = {1'b0, dst[7:1]}; // RL23
        shC = dst[0];
      end
      cbmie_pkg::OP_RLC: begin
        shRes = {dst[6:0], cFlag}; // RL1
        shC = dst[7];
      end
      cbmie_pkg::OP_RRC: begin
        shRes = {cFlag, dst[7:1]}; // RL2
        shC = dst[0];
      end
      cbmie_pkg::OP_SRA: begin
        shRes = {dst[7], dst[7:1]}; // RL3
        shC = dst[0];
      end
      default: begin
        shRes = dst;
        shC = cFlag;
      end
    endcase
  end

  always_comb begin
    stat_nxt = stat_r;
    if (wrStatus) begin
      stat_nxt = hwdata[7:0];
    end else if (exec) begin
      case (op)
        cbmie_pkg::OP_SHR, cbmie_pkg::OP_RLC, cbmie_pkg::OP_RRC, cbmie_pkg::OP_SRA: begin
          stat_nxt[cbmie_pkg::FLAG_C] = shC; // RL1 RL2 RL3 RL23
          stat_nxt[cbmie_pkg::FLAG_Z] = (shRes == 8'h00);
          stat_nxt[cbmie_pkg::FLAG_N] = shRes[7];
          stat_nxt[cbmie_pkg::FLAG_V] = shRes[7] ^ shC;
        end
        cbmie_pkg::OP_BSET: stat_nxt = stat_r | bitMask; // RL6 RL7 RL8 RL9
        cbmie_pkg::OP_BCLR: stat_nxt = stat_r & ~bitMask; // RL6 RL7 RL8 RL9
        cbmie_pkg::OP_B2T: stat_nxt[cbmie_pkg::FLAG_T] = src[cmd_r.bitSel]; // RL4
        default: stat_nxt = stat_r;
      endcase
    end
  end

  // register file write ports: A byte, B second byte of a pair, P pointer pair
  logic wrAEn;
  logic [4:0] wrAIdx;
  logic [7:0] wrAData;
  logic wrBEn;
  logic [4:0] wrBIdx;
  logic [7:0] wrBData;
  logic wrPEn;
  logic [4:0] wrPLo;
  logic [15:0] wrPVal;
  always_comb begin
    wrAEn = 1'b0;
    wrAIdx = cmd_r.rd;
    wrAData = 8'h00;
    wrBEn = 1'b0;
    wrBIdx = {cmd_r.rd[4:1], 1'b1};
    wrBData = regs[{cmd_r.rr[4:1], 1'b1}];
    wrPEn = 1'b0;
    wrPLo = ptrLo;
    wrPVal = ptrNew;
    case (state_r)
      cbmie_pkg::ST_EXEC: begin
        wrPEn = ptrUpd; // RL11 RL12 RL15 RL16
        if (isShift) begin
          wrAEn = 1'b1;
          wrAData = shRes;
        end else if (op == cbmie_pkg::OP_SWAP) begin
          wrAEn = 1'b1;
          wrAData = {dst[3:0], dst[7:4]}; // RL24
        end else if (op == cbmie_pkg::OP_T2B) begin
          wrAEn = 1'b1;
          wrAData = tFlag ? (dst | bitMask) : (dst & ~bitMask); // RL5
        end else if (op == cbmie_pkg::OP_MOV) begin
          wrAEn = 1'b1;
          wrAData = src; // RL10
        end else if (op == cbmie_pkg::OP_MOVP) begin
          wrAEn = 1'b1;
          wrAIdx = {cmd_r.rd[4:1], 1'b0};
          wrAData = regs[{cmd_r.rr[4:1], 1'b0}]; // RL10
          wrBEn = 1'b1;
        end else if (op == cbmie_pkg::OP_LDI) begin
          wrAEn = 1'b1;
          wrAData = const_r[7:0];
        end
      end
      cbmie_pkg::ST_MEM: begin
        wrAEn = isLoad; // RL11 RL12 RL13 RL14 RL22
        wrAData = dmRdData;
      end
      cbmie_pkg::ST_PRD3: begin
        wrAEn = 1'b1;
        wrAIdx = (op == cbmie_pkg::OP_PRD_R0) ? 5'h00 : cmd_r.rd; // RL19
        wrAData = zVal[0] ? pmRdData[15:8] : pmRdData[7:0];
        wrPEn = (op == cbmie_pkg::OP_PRD) && (cmd_r.mode == cbmie_pkg::MODE_POSTINC);
        wrPLo = cbmie_pkg::Z_LO;
        wrPVal = zVal + 16'h0001;
      end
      default: begin
        wrAEn = 1'b0;
      end
    endcase
  end

  for (genvar gi = 0; gi < 32; gi++) begin : g_reg
    localparam logic [4:0] IDX = 5'(gi);
    logic [7:0] q_r;
    wire logic [7:0] qNxt =
      (wrReg && regIdx == IDX) ? hwdata[7:0] :
      (wrAEn && wrAIdx == IDX) ? wrAData :
      (wrBEn && wrBIdx == IDX) ? wrBData :
      (wrPEn && wrPLo == IDX) ? wrPVal[7:0] :
      (wrPEn && wrPLo + 5'h01 == IDX) ? wrPVal[15:8] : q_r;
    always_ff @(posedge clock or posedge rst) begin
      if (rst) q_r <= cbmie_pkg::REG_RESET;
      else q_r <= qNxt;
    end
    assign regs[gi] = q_r;
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      cbmie_pkg::ST_IDLE: if (wrCmd) state_nxt = cbmie_pkg::ST_EXEC;
      cbmie_pkg::ST_EXEC: begin
        if (isMem) state_nxt = cbmie_pkg::ST_MEM;
        else if (isPrd) state_nxt = cbmie_pkg::ST_PRD2;
        else if (isPwr) state_nxt = cbmie_pkg::ST_PWR;
        else state_nxt = cbmie_pkg::ST_IDLE;
      end
      cbmie_pkg::ST_MEM: state_nxt = cbmie_pkg::ST_IDLE;
      cbmie_pkg::ST_PRD2: state_nxt = cbmie_pkg::ST_PRD3;
      cbmie_pkg::ST_PRD3: state_nxt = cbmie_pkg::ST_IDLE;
      cbmie_pkg::ST_PWR: if (pmWrDone) state_nxt = cbmie_pkg::ST_IDLE; // RL20
      default: state_nxt = cbmie_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r <= cbmie_pkg::ST_IDLE;
      cmd_r <= '0;
      const_r <= 16'h0000;
      sp_r <= cbmie_pkg::SP_RESET;
      stat_r <= cbmie_pkg::STATUS_RESET;
    end else begin
      state_r <= state_nxt;
      stat_r <= stat_nxt;
      if (wrCmd) cmd_r <= hwdata[cbmie_pkg::CMD_WIDTH-1:0];
      if (wrConst) const_r <= hwdata[15:0];
      if (wrSp) sp_r <= hwdata[15:0];
      else if (exec && isPush) sp_r <= sp_r - 16'h0001; // RL21
      else if (exec && isPop) sp_r <= sp_r + 16'h0001; // RL22
    end
  end

  // data memory requests stand for exactly the cycle after the execute cycle; program memory requests hold through ST_PRD3 or until pmWrDone
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dmReq <= '0;
      pmReq <= '0;
    end else begin
      if (exec && isMem) dmReq <= '{memAddr, src, isStore, isLoad}; // RL15 RL16 RL17 RL18
      else dmReq <= '0;
      if (exec && isPrd) pmReq <= '{zVal[15:1], 16'h0000, 1'b0, 1'b1}; // RL19
      else if (exec && isPwr) pmReq <= '{zVal[15:1], {regs[1], regs[0]}, 1'b1, 1'b0}; // RL20
      else if (state_r == cbmie_pkg::ST_PRD3) pmReq <= '0;
      else if (state_r == cbmie_pkg::ST_PWR && pmWrDone) pmReq <= '0;
    end
  end

  assign busy = !idle;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  logic [7:0] rdAfter;
  assign rdAfter = regs[cmd_r.rd];

  rotate_left_a: assert property (exec && op == cbmie_pkg::OP_RLC |=> // RL1
    rdAfter == {$past(dst[6:0]), $past(cFlag)} && stat_r[0] == $past(dst[7]))
    else $error("rotate left result or carry wrong");
  rotate_right_a: assert property (exec && op == cbmie_pkg::OP_RRC |=> // RL2
    rdAfter == {$past(cFlag), $past(dst[7:1])} && stat_r[0] == $past(dst[0]))
    else $error("rotate right result or carry wrong");
  arith_shift_a: assert property (exec && op == cbmie_pkg::OP_SRA |=> // RL3
    rdAfter[7] == $past(dst[7]) && stat_r[3] == (stat_r[2] ^ stat_r[0]))
    else $error("arithmetic shift sign or overflow wrong");
  bit_to_t_a: assert property (exec && op == cbmie_pkg::OP_B2T |=> // RL4
    stat_r[6] == $past(src[cmd_r.bitSel]) && stat_r[5:0] == $past(stat_r[5:0]))
    else $error("bit store to transfer flag wrong");
  t_to_bit_a: assert property (exec && op == cbmie_pkg::OP_T2B |=> // RL5
    rdAfter[cmd_r.bitSel] == $past(tFlag) && $stable(stat_r))
    else $error("bit load from transfer flag wrong");
  flag_set_a: assert property (exec && op == cbmie_pkg::OP_BSET |=> // RL6 RL7 RL8 RL9
    stat_r == ($past(stat_r) | bitMask))
    else $error("flag set touched wrong bits");
  flag_clear_a: assert property (exec && op == cbmie_pkg::OP_BCLR |=> // RL6 RL7 RL8 RL9
    stat_r == ($past(stat_r) & ~bitMask))
    else $error("flag clear touched wrong bits");
  reg_move_a: assert property (exec && op == cbmie_pkg::OP_MOV |=> // RL10
    rdAfter == $past(src) && $stable(stat_r))
    else $error("register move wrong");

  sequence memSeq;
    state_r == cbmie_pkg::ST_MEM && dmReq.addr == $past(memAddr) ##1 idle;
  endsequence
  data_access_a: assert property (exec && isMem |=> memSeq) // RL11 RL13 RL14 RL18
    else $error("data access not two cycles");
  post_inc_a: assert property (exec && ptrUpd && cmd_r.mode == cbmie_pkg::MODE_POSTINC |=> // RL15
    ptrVal == $past(ptrVal) + 16'h0001 && dmReq.addr == $past(ptrVal))
    else $error("post increment wrong");
  pre_dec_a: assert property (exec && ptrUpd && // RL12 RL16
    cmd_r.mode == cbmie_pkg::MODE_PREDEC |=>
    ptrVal == $past(ptrVal) - 16'h0001 && dmReq.addr == ptrVal)
    else $error("pre decrement wrong");
  disp_keep_a: assert property (exec && isDisp |=> $stable(ptrVal) [*2]) // RL17
    else $error("displaced access moved pointer");
  stack_pop_a: assert property (exec && isPop |=> // RL22
    dmReq.re && dmReq.addr == sp_r ##1 idle && rdAfter == $past(dmRdData))
    else $error("stack pop wrong");
  stack_push_a: assert property (exec && isPush |=> // RL21
    dmReq.we && dmReq.wdata == $past(src) && sp_r == $past(sp_r) - 16'h0001)
    else $error("stack push wrong");

  sequence progSeq;
    state_r == cbmie_pkg::ST_PRD2 ##1 state_r == cbmie_pkg::ST_PRD3 ##1 idle;
  endsequence
  prog_read_a: assert property (exec && isPrd |=> progSeq) // RL19
    else $error("program read not three cycles");
  prog_write_a: assert property (exec && isPwr |=> // RL20
    pmReq.we && pmReq.wdata == {regs[1], regs[0]} && pmReq.addr == zVal[15:1])
    else $error("program write word wrong");
  shift_right_a: assert property (exec && op == cbmie_pkg::OP_SHR |=> // RL23
    rdAfter == {1'b0, $past(dst[7:1])} && !stat_r[2] && stat_r[0] == $past(dst[0]))
    else $error("logical shift wrong");
  nibble_swap_a: assert property (exec && op == cbmie_pkg::OP_SWAP |=> // RL24
    rdAfter == {$past(dst[3:0]), $past(dst[7:4])} && $stable(stat_r))
    else $error("nibble swap wrong");

endmodule : cbmie_exec

`default_nettype wire

/* cbmie_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none

module cbmie_mem_model #(
  parameter int WR_WAIT = 0
) (
  input wire logic clock,
  input wire cbmie_pkg::cbmie_dmreq_s dmReq,
  output logic [7:0] dmRdData,
  input wire cbmie_pkg::cbmie_pmreq_s pmReq,
  output logic [15:0] pmRdData,
  output logic pmWrDone
);
  logic [7:0] dm [512];
  logic [15:0] pm [256];
  int wCnt = 0;
  initial begin
    pmWrDone = 1'b0;
    for (int i = 0; i < 512; i++) dm[i] = 8'h5A ^ i[7:0];
    for (int i = 0; i < 256; i++) pm[i] = {8'hC3 ^ i[7:0], i[7:0]};
  end
  // outside a read the lines show the inverse, so a late capture is caught
  assign dmRdData = dmReq.re ? dm[dmReq.addr[8:0]] : ~dm[dmReq.addr[8:0]];
  assign pmRdData = pmReq.re ? pm[pmReq.addr[7:0]] : ~pm[pmReq.addr[7:0]];
  always @(posedge clock) begin
    if (dmReq.we) dm[dmReq.addr[8:0]] <= dmReq.wdata;
    if (pmReq.we && !pmWrDone) begin
      if (wCnt == WR_WAIT) begin
        pm[pmReq.addr[7:0]] <= pmReq.wdata;
        pmWrDone <= 1'b1;
      end else begin
        wCnt <= wCnt + 1;
      end
    end else begin
      pmWrDone <= 1'b0;
      wCnt <= 0;
    end
  end
endmodule : cbmie_mem_model

`default_nettype wire

/* test_cpu_bit_move_instr_exec.sv */
`timescale 1ns/1ps
`default_nettype none

module test_cpu_bit_move_instr_exec;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, busy, pmWrDone;
  logic [31:0] hrdata, rv;
  cbmie_pkg::cbmie_dmreq_s dmReq;
  cbmie_pkg::cbmie_pmreq_s pmReq;
  logic [7:0] dmRdData;
  logic [15:0] pmRdData;
  int nErrors = 0;
  int samplesChecked = 0;
  int cycles = 0;
  int busyCnt = 0;

  always #25 clock = ~clock;

  cbmie_exec dut (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .dmReq(dmReq),
    .dmRdData(dmRdData), .pmReq(pmReq), .pmRdData(pmRdData), .pmWrDone(pmWrDone),
    .busy(busy));
  cbmie_mem_model #(.WR_WAIT(4)) mem (.clock(clock), .dmReq(dmReq), .dmRdData(dmRdData),
    .pmReq(pmReq), .pmRdData(pmRdData), .pmWrDone(pmWrDone));

  task automatic stopTest();
    $display("errors %0d checks %0d", nErrors, samplesChecked);
    if (nErrors == 0 && samplesChecked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stopTest

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (busy === 1'b1) busyCnt <= busyCnt + 1;
    if (cycles == 20000) begin
      nErrors++;
      stopTest();
    end
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      nErrors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask : bus

  task automatic rw(input logic [4:0] n, input logic [31:0] d);
    bus(1'b1, {25'h0, n, 2'h0} + 32'h80, d);
  endtask : rw

  task automatic rr(input logic [4:0] n);
    bus(1'b0, {25'h0, n, 2'h0} + 32'h80, 32'h0);
  endtask : rr

  // issue a command, wait for busy to drop, check how long it stood
  task automatic run(input logic [31:0] c, input int cyc);
    int b0;
    b0 = busyCnt;
    bus(1'b1, 32'h0, c);
    do bus(1'b0, 32'h8, 32'h0); while (rv[8] !== 1'b0);
    if (cyc > 0) chk("cycles", busyCnt - b0, cyc);
  endtask : run

  function automatic logic [31:0] mk(input logic [4:0] op, rd, rs, input logic [2:0] b,
      input logic [1:0] p, m);
    return {10'h0, m, p, b, rs, rd, op};
  endfunction : mk

  // {carry out, result}
  function automatic logic [8:0] shf(input logic [4:0] op, input logic [7:0] v, input logic c);
    case (op)
      5'h01: return {v[0], 1'b0, v[7:1]};
      5'h02: return {v[7], v[6:0], c};
      5'h03: return {v[0], c, v[7:1]};
      default: return {v[0], v[7], v[7:1]};
    endcase
  endfunction : shf

  initial begin
    logic [8:0] e;
    logic [7:0] v;
    logic [4:0] lo;
    logic [15:0] pa;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    bus(1'b0, 32'h8, 32'h0);
    chk("status", rv, 32'h0);
    bus(1'b0, 32'hC, 32'h0);
    chk("sp", rv, 32'h1FF);
    chk("hresp", {31'h0, hresp}, 32'h0);
    bus(1'b0, 32'h40, 32'h0);
    chk("unmapped", rv, 32'h0);
    for (int i = 1; i <= 4; i++) for (int k = 0; k < 4; k++) begin
      v = k[1] ? 8'h01 : 8'h81;
      rw(5'h10, {24'h0, v});
      bus(1'b1, 32'h8, {24'h0, 8'h90 | {7'h0, k[0]}});
      run(mk(i[4:0], 5'h10, 5'h0, 3'h0, 2'h0, 2'h0), 1);
      e = shf(i[4:0], v, k[0]);
      rr(5'h10);
      chk("shift", rv, {24'h0, e[7:0]});
      bus(1'b0, 32'h8, 32'h0);
      chk("shiftflags", rv, {24'h9, e[7] ^ e[8], e[7], e[7:0] == 8'h0, e[8]});
    end
    rw(5'h10, 32'h3C);
    bus(1'b1, 32'h8, 32'hA5);
    run(mk(5'h05, 5'h10, 5'h0, 3'h0, 2'h0, 2'h0), 1);
    rr(5'h10);
    chk("swap", rv, 32'hC3);
    bus(1'b0, 32'h8, 32'h0);
    chk("swapflags", rv, 32'hA5);
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, 32'h8, 32'h0);
      run(mk(5'h06, 5'h0, 5'h0, i[2:0], 2'h0, 2'h0), 1);
      chk("flagset", rv, 32'h1 << i);
      bus(1'b1, 32'h8, 32'hFF);
      run(mk(5'h07, 5'h0, 5'h0, i[2:0], 2'h0, 2'h0), 1);
      chk("flagclr", rv, 32'hFF ^ (32'h1 << i));
    end
    rw(5'h03, 32'h20);
    bus(1'b1, 32'h8, 32'hBF);
    run(mk(5'h08, 5'h0, 5'h03, 3'h5, 2'h0, 2'h0), 1);
    chk("tflag", rv, 32'hFF);
    bus(1'b1, 32'h8, 32'h40);
    run(mk(5'h09, 5'h04, 5'h0, 3'h6, 2'h0, 2'h0), 1);
    rr(5'h04);
    chk("bitload", rv, 32'h40);
    rw(5'h02, 32'h11);
    run(mk(5'h0A, 5'h07, 5'h03, 3'h0, 2'h0, 2'h0), 1);
    rr(5'h07);
    chk("move", rv, 32'h20);
    run(mk(5'h0B, 5'h08, 5'h02, 3'h0, 2'h0, 2'h0), 1);
    rr(5'h08);
    chk("pairlo", rv, 32'h11);
    rr(5'h09);
    chk("pairhi", rv, 32'h20);
    for (int s = 0; s < 2; s++) for (int p = 0; p < 3; p++) for (int m = 0; m < 3; m++) begin
      lo = 5'h1A + {p[3:0], 1'b0};
      rw(lo, 32'h0);
      rw(lo + 5'h1, 32'h1);
      rw(5'h05, 32'hA0 + m);
      run(mk(s ? 5'h10 : 5'h0D, 5'h05, 5'h05, 3'h0, p[1:0], m[1:0]), 2);
      pa = (m == 2) ? 16'h00FF : 16'h0100;
      rr(5'h05);
      if (s == 0) chk("load", rv, {24'h0, 8'h5A ^ pa[7:0]});
      else chk("store", {24'h0, mem.dm[pa[8:0]]}, 32'hA0 + m);
      rr(lo);
      e[7:0] = rv[7:0];
      rr(lo + 5'h1);
      chk("pointer", {rv[7:0], e[7:0]}, (m == 1) ? 32'h101 : {16'h0, pa});
    end
    bus(1'b1, 32'h4, 32'h3F);
    for (int s = 0; s < 2; s++) for (int p = 1; p < 3; p++) begin
      lo = 5'h1A + {p[3:0], 1'b0};
      rw(lo, 32'h0);
      rw(lo + 5'h1, 32'h1);
      rw(5'h06, 32'hC0 + p);
      run(mk(s ? 5'h11 : 5'h0E, 5'h06, 5'h06, 3'h0, p[1:0], 2'h0), 2);
      rr(5'h06);
      if (s == 0) chk("dispload", rv, 32'h65);
      else chk("dispstore", {24'h0, mem.dm[9'h13F]}, 32'hC0 + p);
      rr(lo);
      chk("dispptr", rv, 32'h0);
    end
    bus(1'b1, 32'h4, 32'h1A5);
    run(mk(5'h0F, 5'h06, 5'h0, 3'h0, 2'h0, 2'h0), 2);
    rr(5'h06);
    chk("dirload", rv, 32'hFF);
    rw(5'h06, 32'h3C);
    run(mk(5'h12, 5'h06, 5'h06, 3'h0, 2'h0, 2'h0), 2);
    chk("dirstore", {24'h0, mem.dm[9'h1A5]}, 32'h3C);
    bus(1'b1, 32'h4, 32'h5E);
    run(mk(5'h0C, 5'h0B, 5'h0, 3'h0, 2'h0, 2'h0), 1);
    rr(5'h0B);
    chk("immediate", rv, 32'h5E);
    rw(5'h1E, 32'h23);
    rw(5'h1F, 32'h0);
    run(mk(5'h13, 5'h09, 5'h0, 3'h0, 2'h0, 2'h1), 3);
    rr(5'h09);
    chk("progread", rv, 32'hD2);
    rr(5'h1E);
    chk("zinc", rv, 32'h24);
    run(mk(5'h14, 5'h0, 5'h0, 3'h0, 2'h0, 2'h0), 3);
    rr(5'h00);
    chk("progreadr0", rv, 32'h12);
    rw(5'h00, 32'hEF);
    rw(5'h01, 32'hBE);
    rw(5'h1E, 32'h40);
    bus(1'b1, 32'h0, mk(5'h15, 5'h0, 5'h0, 3'h0, 2'h0, 2'h0));
    rw(5'h14, 32'h55);
    do bus(1'b0, 32'h8, 32'h0); while (rv[8] !== 1'b0);
    chk("progwrite", {16'h0, mem.pm[8'h20]}, 32'hBEEF);
    rr(5'h14);
    chk("busywrite", rv, 32'h0);
    rw(5'h05, 32'h77);
    run(mk(5'h16, 5'h05, 5'h05, 3'h0, 2'h0, 2'h0), 2);
    chk("push", {24'h0, mem.dm[9'h1FF]}, 32'h77);
    bus(1'b0, 32'hC, 32'h0);
    chk("sppush", rv, 32'h1FE);
    run(mk(5'h17, 5'h06, 5'h0, 3'h0, 2'h0, 2'h0), 2);
    rr(5'h06);
    chk("pop", rv, 32'h77);
    bus(1'b0, 32'hC, 32'h0);
    chk("sppop", rv, 32'h1FF);
    bus(1'b0, 32'h8, 32'h0);
    chk("memflags", rv, 32'h40);
    stopTest();
  end
endmodule : test_cpu_bit_move_instr_exec

`default_nettype wire
